// ---- rtl/arx_top.sv ----
// Behaviour
// RQ1: Receive mux picks receive pins normally, transmit outputs during external loopback.
// RQ2: Bias pull bit in register 02 makes receive input bias internal.
// RQ3: Caller-ID bit one adds 20 dB receive gain; zero adds none.
// RQ4: Gain code 00=6dB, 01=9dB, 10=12dB, 11=0dB.
// RQ5: Modulator tick runs 1.536 MHz at 8 kHz, scales with programmed rate.
// RQ6: Sinc-cubed filters emit one sample per 96 modulator bits.
// RQ7: Sinc-cubed output is a 17-bit two's complement value.
// RQ8: A 48-tap correction FIR follows the sinc-cubed stage.
// RQ9: FIR output decimated by two gives 16-bit samples at sample rate.
// RQ10: Register 01h bit 4 routes receive bit stream into transmitter input.
// RQ11: Register 01h bit 5 feeds transmit outputs back into receive input.
// RQ12: Host keeps transmit codes under 25 percent scale during external loopback.
// RQ13: Register 01h bit 6 routes transmit bit stream into sinc-cubed filters.
// RQ14: Front-end enable bit 7 of register 00h zero stops filter clocks.
// RQ15: With front end off, registers stay readable and writable.
// RQ16: Front-end enable bit is zero after reset.
// RQ17: No loopback: filters take receive stream, transmitter takes host samples.
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "arx_regs.svh"

module arx_top
	import arx_pkg::*;
#(
	parameter int NCO_W = 24,
	parameter int OUT_W = 16
)(
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              rx_bit_stream,
	input  wire logic              tx_bit_stream,
	output logic                   rx_mux_sel_tx,
	output logic                   rx_bias_pull,
	output logic                   caller_id_boost,
	output logic [1:0]             rx_gain_sel,
	output logic [3:0]             rx_gain_db,
	output logic                   internal_loop_en,
	output logic                   external_loop_en,
	output logic                   digital_loop_en,
	output logic                   front_end_enable,
	output logic                   mod_clk_en,
	output logic                   tx_in_sel_rx,
	output logic                   tx_loop_bit,
	output logic [OUT_W-1:0]       rx_sample,
	output logic                   rx_sample_valid
);

	// ============================================================
	// State
	typedef struct packed {
		logic             fe_en;
		logic             int_loop;
		logic             ext_loop;
		logic             dig_loop;
		logic             cid;
		logic [1:0]       gain;
		logic [3:0]       gain_db;
		logic             bias;
		logic             mux_sel;
		logic             tx_sel;
		logic             loop_bit;
		logic [NCO_W-1:0] mod_inc;
		logic [NCO_W-1:0] nco;
		logic             mod_tick;
		logic [5:0]       coef_addr;
		logic             rx_sync1;
		logic             rx_sync2;
		logic             wait_r;
		logic [31:0]      rdata;
		logic [OUT_W-1:0] sample;
		logic             svalid;
	} arx_top_state_t;

	// Reset image: everything off, bus stalled, nominal modulator rate
	function automatic arx_top_state_t rst_state();
		arx_top_state_t s;
		s = '0;
		s.fe_en = 1'b0;                     // [RQ16]
		s.mod_inc = `ARX_RST_MOD_INC;
		s.wait_r = 1'b1;
		s.gain_db = arx_gain_db(2'h0);
		return s;
	endfunction

	localparam arx_top_state_t ST_RST = rst_state();

	arx_top_state_t st_ff;
	arx_top_state_t nxt_st;

	// ============================================================
	// Filter path wiring
	logic                 sinc_bit;
	logic signed [16:0]   sinc_sample;
	logic                 sinc_valid;
	logic                 coef_we;
	logic [15:0]          coef_rdata;
	logic [OUT_W-1:0]     fir_sample;
	logic                 fir_valid;
	logic [5:0]           reg_idx;
	logic                 bus_commit;

	// Digital loopback wins over the receive stream at the filter input
	assign sinc_bit = st_ff.dig_loop ? tx_bit_stream : st_ff.rx_sync2;   // [RQ13] [RQ17]

	// Byte address to register index; low address bits ignored
	assign reg_idx = avs_address[7:2];

	// The edge at which the master sees waitrequest low
	assign bus_commit = !st_ff.wait_r && (avs_read || avs_write);

	assign coef_we = bus_commit && avs_write && (reg_idx == `ARX_IDX_COEF);

	// ============================================================
	// Decimation chain
	arx_sinc3 #(
		.DECIM (`ARX_SINC_DECIM)
	) u_sinc3 (
		.mclk         (mclk),
		.resetn       (resetn),
		.bit_en       (st_ff.mod_tick),
		.bit_in       (sinc_bit),
		.sample       (sinc_sample),
		.sample_valid (sinc_valid)
	);

	arx_fir #(
		.TAPS  (`ARX_FIR_TAPS),
		.OUT_W (OUT_W),
		.DECIM (`ARX_FIR_DECIM)
	) u_fir (
		.mclk       (mclk),
		.resetn     (resetn),
		.in_valid   (sinc_valid),
		.in_sample  (sinc_sample),
		.coef_we    (coef_we),
		.coef_addr  (avs_writedata[`ARX_POS_COEF_ADDR +: 6]),
		.coef_wdata (avs_writedata[15:0]),
		.coef_raddr (st_ff.coef_addr),
		.coef_rdata (coef_rdata),
		.out_sample (fir_sample),
		.out_valid  (fir_valid)
	);

	// ============================================================
	// Next-state logic
	always_comb
	begin
		logic [NCO_W:0] nco_sum;
		nco_sum = '0;
		nxt_st = st_ff;
		nxt_st.mod_tick = 1'b0;
		nxt_st.svalid = 1'b0;

		// Two-stage synchroniser for the analog modulator stream
		nxt_st.rx_sync1 = rx_bit_stream;
		nxt_st.rx_sync2 = st_ff.rx_sync1;

		// Fractional divider: carry out of the accumulator is the modulator tick.
		// Jitter of one mclk period is traded for any programmable rate.
		if (st_ff.fe_en)
		begin
			nco_sum = {1'b0, st_ff.nco} + {1'b0, st_ff.mod_inc};   // [RQ5]
			nxt_st.nco = nco_sum[NCO_W-1:0];
			nxt_st.mod_tick = nco_sum[NCO_W];
		end
		else
		begin
			// Filters see no tick at all, so they hold still
			nxt_st.nco = '0;                                        // [RQ14]
		end

		// Bit fed to the transmitter during internal loopback; cleared as soon as the
		// loop is left, since with the front end off no tick would ever clear it
		if (!st_ff.int_loop)
			nxt_st.loop_bit = 1'b0;                                 // [RQ17]
		else if (st_ff.mod_tick)
			nxt_st.loop_bit = st_ff.rx_sync2;                       // [RQ10]

		// Latest receive sample for the status register; a MAC pass that ends after
		// power-down is dropped, as its filter clock would have stopped
		if (fir_valid && st_ff.fe_en)                               // [RQ14]
		begin
			nxt_st.sample = fir_sample;                             // [RQ9]
			nxt_st.svalid = 1'b1;
		end

		// Bus slave: one wait cycle, then the transfer completes.
		// Decoding ignores the front-end enable so software always has access.
		if (st_ff.wait_r)
		begin
			if (avs_read || avs_write)
			begin
				nxt_st.wait_r = 1'b0;
				nxt_st.rdata = 32'h0;
				if (avs_read)
				begin
					case (reg_idx)
						`ARX_IDX_FE_CTRL:
							nxt_st.rdata[`ARX_BIT_FE_EN] = st_ff.fe_en;   // [RQ15]
						`ARX_IDX_RX_CTRL:
						begin
							nxt_st.rdata[`ARX_BIT_DIG_LOOP] = st_ff.dig_loop;
							nxt_st.rdata[`ARX_BIT_EXT_LOOP] = st_ff.ext_loop;
							nxt_st.rdata[`ARX_BIT_INT_LOOP] = st_ff.int_loop;
							nxt_st.rdata[`ARX_BIT_CID_BOOST] = st_ff.cid;
							nxt_st.rdata[`ARX_BIT_GAIN_LO +: 2] = st_ff.gain;
						end
						`ARX_IDX_AUX_CTRL:
							nxt_st.rdata[`ARX_BIT_BIAS_PULL] = st_ff.bias;
						`ARX_IDX_STATUS:
						begin
							nxt_st.rdata[OUT_W-1:0] = st_ff.sample;
							nxt_st.rdata[`ARX_BIT_STAT_FE] = st_ff.fe_en;
						end
						`ARX_IDX_MOD_INC:
							nxt_st.rdata[NCO_W-1:0] = st_ff.mod_inc;
						`ARX_IDX_COEF:
						begin
							nxt_st.rdata[15:0] = coef_rdata;
							nxt_st.rdata[`ARX_POS_COEF_ADDR +: 6] = st_ff.coef_addr;
						end
						default:
							nxt_st.rdata = 32'h0;
					endcase
				end
			end
		end
		else
		begin
			nxt_st.wait_r = 1'b1;
			if (avs_write)
			begin
				case (reg_idx)
					`ARX_IDX_FE_CTRL:
						nxt_st.fe_en = avs_writedata[`ARX_BIT_FE_EN];     // [RQ14] [RQ15]
					`ARX_IDX_RX_CTRL:
					begin
						nxt_st.dig_loop = avs_writedata[`ARX_BIT_DIG_LOOP];   // [RQ13]
						nxt_st.ext_loop = avs_writedata[`ARX_BIT_EXT_LOOP];   // [RQ11]
						nxt_st.int_loop = avs_writedata[`ARX_BIT_INT_LOOP];   // [RQ10]
						nxt_st.cid = avs_writedata[`ARX_BIT_CID_BOOST];       // [RQ3]
						nxt_st.gain = avs_writedata[`ARX_BIT_GAIN_LO +: 2];  // [RQ4]
					end
					`ARX_IDX_AUX_CTRL:
						nxt_st.bias = avs_writedata[`ARX_BIT_BIAS_PULL];  // [RQ2]
					`ARX_IDX_MOD_INC:
						nxt_st.mod_inc = avs_writedata[NCO_W-1:0];        // [RQ5]
					`ARX_IDX_COEF:
						nxt_st.coef_addr = avs_writedata[`ARX_POS_COEF_ADDR +: 6];
					default:
						nxt_st.fe_en = st_ff.fe_en;
				endcase
			end
		end

		// Analog controls follow the control bits one cycle later
		nxt_st.gain_db = arx_gain_db(st_ff.gain);                    // [RQ4]
		nxt_st.mux_sel = st_ff.ext_loop;                             // [RQ1] [RQ11]
		nxt_st.tx_sel = st_ff.int_loop;                              // [RQ10] [RQ17]
	end

	// ============================================================
	// State register
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	// ============================================================
	// Outputs, all straight from the state register
	assign avs_readdata = st_ff.rdata;
	assign avs_waitrequest = st_ff.wait_r;
	assign rx_mux_sel_tx = st_ff.mux_sel;                            // [RQ1]
	assign rx_bias_pull = st_ff.bias;                                // [RQ2]
	assign caller_id_boost = st_ff.cid;                              // [RQ3]
	assign rx_gain_sel = st_ff.gain;
	assign rx_gain_db = st_ff.gain_db;
	assign internal_loop_en = st_ff.int_loop;
	assign external_loop_en = st_ff.ext_loop;
	assign digital_loop_en = st_ff.dig_loop;
	assign front_end_enable = st_ff.fe_en;                           // [RQ14]
	assign mod_clk_en = st_ff.mod_tick;
	assign tx_in_sel_rx = st_ff.tx_sel;
	assign tx_loop_bit = st_ff.loop_bit;
	assign rx_sample = st_ff.sample;
	assign rx_sample_valid = st_ff.svalid;

endmodule

// ---- rtl/arx_regs.svh ----
`ifndef ARX_REGS_SVH
`define ARX_REGS_SVH

// ============================================================
// Register indices (byte address = index * 4)
`define ARX_IDX_FE_CTRL     6'h00
`define ARX_IDX_RX_CTRL     6'h01
`define ARX_IDX_AUX_CTRL    6'h02
`define ARX_IDX_STATUS      6'h03
`define ARX_IDX_MOD_INC     6'h04
`define ARX_IDX_COEF        6'h05

// ============================================================
// Field positions
`define ARX_BIT_FE_EN       7
`define ARX_BIT_DIG_LOOP    6
`define ARX_BIT_EXT_LOOP    5
`define ARX_BIT_INT_LOOP    4
`define ARX_BIT_CID_BOOST   3
`define ARX_BIT_GAIN_LO     0
`define ARX_BIT_BIAS_PULL   0
`define ARX_BIT_STAT_FE     16
`define ARX_POS_COEF_ADDR   16

// ============================================================
// Reset values
`define ARX_RST_MOD_INC     24'h07dd44
`define ARX_RST_CENTER_COEF 16'h7fff

// ============================================================
// Rates and filter shape
`define ARX_MCLK_HZ         50000000
`define ARX_MOD_HZ_AT_8K    1536000
`define ARX_SINC_DECIM      96
`define ARX_FIR_TAPS        48
`define ARX_FIR_DECIM       2

`endif

// ---- rtl/arx_pkg.sv ----
package arx_pkg;

	// ============================================================
	// Correction filter sequencer
	typedef enum logic [1:0] {
		ARX_FIR_IDLE,
		ARX_FIR_MAC,
		ARX_FIR_OUT
	} arx_fir_st_t;

	// Receive gain code to gain in dB
	function automatic logic [3:0] arx_gain_db(input logic [1:0] code);
		logic [3:0] db;
		db = 4'h0;
		case (code)
			2'h0: db = 4'h6;
			2'h1: db = 4'h9;
			2'h2: db = 4'hc;
			default: db = 4'h0;
		endcase
		return db;
	endfunction

endpackage

// ---- rtl/arx_sinc3.sv ----
`timescale 1ns/1ps
`include "arx_regs.svh"

module arx_sinc3
	import arx_pkg::*;
#(
	parameter int DECIM = `ARX_SINC_DECIM,
	parameter int ACC_W = 22,
	parameter int OUT_W = 17,
	parameter int SHIFT = 4
)(
	input  wire logic                    mclk,
	input  wire logic                    resetn,
	input  wire logic                    bit_en,
	input  wire logic                    bit_in,
	output logic signed [OUT_W-1:0]      sample,
	output logic                         sample_valid
);

	typedef struct packed {
		logic [ACC_W-1:0] i1;
		logic [ACC_W-1:0] i2;
		logic [ACC_W-1:0] i3;
		logic [ACC_W-1:0] z1;
		logic [ACC_W-1:0] z2;
		logic [ACC_W-1:0] z3;
		logic [6:0]       cnt;
		logic [OUT_W-1:0] out;
		logic             valid;
	} arx_sinc_state_t;

	arx_sinc_state_t st_ff;
	arx_sinc_state_t nxt_st;

	// ============================================================
	// Integrators at the bit rate, combs at the decimated rate
	always_comb
	begin
		logic [ACC_W-1:0] x;
		logic [ACC_W-1:0] d1;
		logic [ACC_W-1:0] d2;
		logic [ACC_W-1:0] d3;
		x = '0;
		d1 = '0;
		d2 = '0;
		d3 = '0;
		nxt_st = st_ff;
		nxt_st.valid = 1'b0;
		if (bit_en)
		begin
			// One bit maps to +1 or -1; wrap-around arithmetic is harmless in a CIC
			x = bit_in ? ACC_W'(1) : {ACC_W{1'b1}};
			nxt_st.i1 = st_ff.i1 + x;
			nxt_st.i2 = st_ff.i2 + st_ff.i1;
			nxt_st.i3 = st_ff.i3 + st_ff.i2;
			nxt_st.cnt = st_ff.cnt + 7'h01;
			if (st_ff.cnt == 7'(DECIM - 1))   // [RQ6]
			begin
				nxt_st.cnt = 7'h00;
				d1 = st_ff.i3 - st_ff.z1;
				d2 = d1 - st_ff.z2;
				d3 = d2 - st_ff.z3;
				nxt_st.z1 = st_ff.i3;
				nxt_st.z2 = d1;
				nxt_st.z3 = d2;
				nxt_st.out = d3[SHIFT +: OUT_W];   // [RQ7]
				nxt_st.valid = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign sample = st_ff.out;
	assign sample_valid = st_ff.valid;

endmodule

// ---- rtl/arx_fir.sv ----
`timescale 1ns/1ps
`include "arx_regs.svh"

module arx_fir
	import arx_pkg::*;
#(
	parameter int TAPS   = `ARX_FIR_TAPS,
	parameter int IN_W   = 17,
	parameter int OUT_W  = 16,
	parameter int COEF_W = 16,
	parameter int DECIM  = `ARX_FIR_DECIM,
	parameter int SHIFT  = 16
)(
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic              in_valid,
	input  wire logic [IN_W-1:0]   in_sample,
	input  wire logic              coef_we,
	input  wire logic [5:0]        coef_addr,
	input  wire logic [COEF_W-1:0] coef_wdata,
	input  wire logic [5:0]        coef_raddr,
	output logic [COEF_W-1:0]      coef_rdata,
	output logic [OUT_W-1:0]       out_sample,
	output logic                   out_valid
);

	localparam int ACC_W = 40;
	localparam logic signed [ACC_W-1:0] MAX_OUT = ACC_W'((2 ** (OUT_W - 1)) - 1);
	localparam logic signed [ACC_W-1:0] MIN_OUT = -ACC_W'(2 ** (OUT_W - 1));

	typedef struct packed {
		logic [TAPS-1:0][IN_W-1:0]   hist;
		logic [TAPS-1:0][COEF_W-1:0] coef;
		logic [3:0]                  phase;
		arx_fir_st_t                 fsm;
		logic [5:0]                  idx;
		logic [ACC_W-1:0]            acc;
		logic [OUT_W-1:0]            out;
		logic                        valid;
	} arx_fir_state_t;

	// Pass-through by default: a single center tap until software loads a set
	function automatic arx_fir_state_t rst_state();
		arx_fir_state_t s;
		s = '0;
		s.fsm = ARX_FIR_IDLE;
		s.coef[TAPS/2] = `ARX_RST_CENTER_COEF;
		return s;
	endfunction

	localparam arx_fir_state_t ST_RST = rst_state();

	arx_fir_state_t st_ff;
	arx_fir_state_t nxt_st;

	// ============================================================
	// Serial multiply-accumulate, one output per DECIM inputs
	always_comb
	begin
		logic signed [ACC_W-1:0] prod;
		logic signed [ACC_W-1:0] scaled;
		prod = '0;
		scaled = '0;
		nxt_st = st_ff;
		nxt_st.valid = 1'b0;
		// Tap addresses past the last tap are ignored rather than written off the end
		if (coef_we && (coef_addr < 6'(TAPS)))
			nxt_st.coef[coef_addr] = coef_wdata;
		// Inputs arrive at least 96 cycles apart (thousands at the reset rate), longer than a MAC pass
		if (in_valid)
		begin
			nxt_st.hist = {st_ff.hist[TAPS-2:0], in_sample};   // [RQ8]
			nxt_st.phase = st_ff.phase + 4'h1;
			if (st_ff.phase == 4'(DECIM - 1))   // [RQ9]
			begin
				nxt_st.phase = 4'h0;
				nxt_st.fsm = ARX_FIR_MAC;
				nxt_st.idx = 6'h00;
				nxt_st.acc = '0;
			end
		end
		case (st_ff.fsm)
			ARX_FIR_IDLE:
				;
			ARX_FIR_MAC:
			begin
				// Widen both operands first so the product is never cut to 17 bits
				prod = ACC_W'($signed(st_ff.hist[st_ff.idx])) *
					ACC_W'($signed(st_ff.coef[st_ff.idx]));
				nxt_st.acc = st_ff.acc + prod;   // [RQ8]
				nxt_st.idx = st_ff.idx + 6'h01;
				if (st_ff.idx == 6'(TAPS - 1))
					nxt_st.fsm = ARX_FIR_OUT;
			end
			ARX_FIR_OUT:
			begin
				// Saturate rather than wrap so an overload clips cleanly
				scaled = $signed(st_ff.acc) >>> SHIFT;
				if (scaled > MAX_OUT)
					nxt_st.out = MAX_OUT[OUT_W-1:0];
				else if (scaled < MIN_OUT)
					nxt_st.out = MIN_OUT[OUT_W-1:0];
				else
					nxt_st.out = scaled[OUT_W-1:0];   // [RQ9]
				nxt_st.valid = 1'b1;
				nxt_st.fsm = ARX_FIR_IDLE;
			end
			default:
				nxt_st.fsm = ARX_FIR_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	assign coef_rdata = (coef_raddr < 6'(TAPS)) ? st_ff.coef[coef_raddr] : '0;
	assign out_sample = st_ff.out;
	assign out_valid = st_ff.valid;

endmodule

// ---- tb/arx_top_assertions.sv ----
`timescale 1ns/1ps

module arx_top_chk
	import arx_pkg::*;
#(
	parameter int NCO_W = 24,
	parameter int OUT_W = 16
)(
	input wire logic             mclk,
	input wire logic             resetn,
	input wire logic             avs_read,
	input wire logic             avs_write,
	input wire logic             avs_waitrequest,
	input wire logic             rx_mux_sel_tx,
	input wire logic [1:0]       rx_gain_sel,
	input wire logic [3:0]       rx_gain_db,
	input wire logic             internal_loop_en,
	input wire logic             external_loop_en,
	input wire logic             front_end_enable,
	input wire logic             mod_clk_en,
	input wire logic             tx_in_sel_rx,
	input wire logic             tx_loop_bit,
	input wire logic [OUT_W-1:0] rx_sample,
	input wire logic             rx_sample_valid
);
	// ============================================================
	// Bus, routing and power-down relations
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered after one cycle");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_mux_follow: assert property (1'b1 |=> rx_mux_sel_tx == $past(external_loop_en))
		else $error("receive mux select does not follow external loop bit");
	a_gain_decode: assert property (1'b1 |=> rx_gain_db == (($past(rx_gain_sel) == 2'h0) ? 4'h6 :
		($past(rx_gain_sel) == 2'h1) ? 4'h9 : ($past(rx_gain_sel) == 2'h2) ? 4'hc : 4'h0))
		else $error("receive gain decode wrong");
	a_tx_select: assert property (1'b1 |=> tx_in_sel_rx == $past(internal_loop_en))
		else $error("transmit input select does not follow internal loop bit");
	a_loop_quiet: assert property (!internal_loop_en [*2] |-> !tx_loop_bit)
		else $error("loop bit active without internal loop");
	a_tick_off: assert property (!front_end_enable [*2] |-> !mod_clk_en)
		else $error("modulator tick while front end off");
	a_valid_off: assert property (!front_end_enable [*8] |-> !rx_sample_valid)
		else $error("sample output while front end off");
	a_valid_pulse: assert property (rx_sample_valid |=> !rx_sample_valid [*8])
		else $error("samples closer than decimation allows");
	a_tick_pulse: assert property (mod_clk_en |=> !mod_clk_en)
		else $error("modulator tick longer than one cycle");

	// Main scenarios reached
	c_sample: cover property (rx_sample_valid);
	c_ext_loop: cover property (rx_mux_sel_tx && mod_clk_en);
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind arx_top arx_top_chk #(.NCO_W(NCO_W), .OUT_W(OUT_W)) u_chk (
	.mclk(mclk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .rx_mux_sel_tx(rx_mux_sel_tx),
	.rx_gain_sel(rx_gain_sel), .rx_gain_db(rx_gain_db), .internal_loop_en(internal_loop_en),
	.external_loop_en(external_loop_en), .front_end_enable(front_end_enable),
	.mod_clk_en(mod_clk_en), .tx_in_sel_rx(tx_in_sel_rx), .tx_loop_bit(tx_loop_bit),
	.rx_sample(rx_sample), .rx_sample_valid(rx_sample_valid));

// ---- tb/arx_far_end.sv ----
`timescale 1ns/1ps

module arx_far_end (
	input wire logic mclk,
	input wire logic tick,
	input wire logic rx_level,
	input wire logic tx_level,
	input wire logic tx_in_sel_rx,
	input wire logic tx_loop_bit,
	output logic     rx_bit_stream,
	output logic     tx_bit_stream
);
	// ============================================================
	// Modulator streams, one new bit per tick
	// External loopback is not modelled; rx_bit_stream follows rx_level only
	initial
	begin
		rx_bit_stream = 1'b0;
		tx_bit_stream = 1'b0;
	end
	always @(posedge mclk)
	begin
		if (tick)
		begin
			rx_bit_stream <= rx_level;
			tx_bit_stream <= tx_in_sel_rx ? tx_loop_bit : tx_level;
		end
	end
endmodule

// ---- tb/test_afe_receive_decimation_loopback.sv ----
`timescale 1ns/1ps

module test_afe_receive_decimation_loopback;
	// ============================================================
	// Stimulus and observed signals
	logic        mclk, resetn, avs_read, avs_write, avs_waitrequest;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, v;
	logic        rx_bit_stream, tx_bit_stream, rx_level, tx_level;
	logic        rx_mux_sel_tx, rx_bias_pull, caller_id_boost, mod_clk_en;
	logic        internal_loop_en, external_loop_en, digital_loop_en;
	logic        front_end_enable, tx_in_sel_rx, tx_loop_bit, rx_sample_valid;
	logic [1:0]  rx_gain_sel;
	logic [3:0]  rx_gain_db;
	logic [15:0] rx_sample;
	logic [3:0]  gain_db [4] = '{4'h6, 4'h9, 4'hc, 4'h0};
	int          n_errors = 0, n_compared = 0, n, e;

	arx_top dut (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rx_bit_stream(rx_bit_stream), .tx_bit_stream(tx_bit_stream),
		.rx_mux_sel_tx(rx_mux_sel_tx), .rx_bias_pull(rx_bias_pull),
		.caller_id_boost(caller_id_boost), .rx_gain_sel(rx_gain_sel), .rx_gain_db(rx_gain_db),
		.internal_loop_en(internal_loop_en), .external_loop_en(external_loop_en),
		.digital_loop_en(digital_loop_en), .front_end_enable(front_end_enable),
		.mod_clk_en(mod_clk_en), .tx_in_sel_rx(tx_in_sel_rx), .tx_loop_bit(tx_loop_bit),
		.rx_sample(rx_sample), .rx_sample_valid(rx_sample_valid));

	arx_far_end far (.mclk(mclk), .tick(mod_clk_en), .rx_level(rx_level), .tx_level(tx_level),
		.tx_in_sel_rx(tx_in_sel_rx), .tx_loop_bit(tx_loop_bit),
		.rx_bit_stream(rx_bit_stream), .tx_bit_stream(tx_bit_stream));

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ============================================================
	// Shared tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until waitrequest is sampled low
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask

	// Some controls show one edge after the write completes
	task settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask

	task ticks(input int cyc);
		n = 0;
		repeat (cyc)
		begin
			@(posedge mclk);
			if (mod_clk_en === 1'b1)
				n++;
		end
	endtask

	task wait_valid;
		do @(posedge mclk); while (rx_sample_valid !== 1'b1);
	endtask

	// ============================================================
	// Scenarios
	task t_reset;
		rd(8'h00, v);
		chk(v, 32'h0);
		chk(front_end_enable, 1'b0);
		rd(8'h10, v);
		chk(v, 32'h07dd44);
		wr(8'h0c, 32'h1ffff);
		rd(8'h0c, v);
		chk(v, 32'h0);
		rd(8'h3c, v);
		chk(v, 32'h0);
		$display("test reset done");
	endtask

	task t_regs;
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h04, {28'h0, i[0], 1'b0, i[1:0]});
			settle();
			chk(rx_gain_sel, i[1:0]);
			chk(rx_gain_db, gain_db[i]);
			chk(caller_id_boost, i[0]);
		end
		wr(8'h08, 32'h1);
		settle();
		chk(rx_bias_pull, 1'b1);
		wr(8'h08, 32'h0);
		settle();
		chk(rx_bias_pull, 1'b0);
		wr(8'h04, 32'h0);
		$display("test control fields done");
	endtask

	task t_power;
		ticks(300);
		chk(n, 0);
		wr(8'h14, 32'h00051234);
		rd(8'h14, v);
		chk(v, 32'h00051234);
		wr(8'h14, 32'h00050000);
		$display("test power down done");
	endtask

	task t_rate;
		wr(8'h00, 32'h80);
		settle();
		chk(front_end_enable, 1'b1);
		e = int'((64'd1000 * 64'h07dd44) >> 24);
		ticks(1000);
		chk(n == e || n == e + 1, 1'b1);
		wr(8'h10, 32'h800000);
		settle();
		ticks(100);
		chk(n, 50);
		$display("test modulator rate done");
	endtask

	task t_loops;
		rx_level <= 1'b1;
		for (int b = 4; b < 7; b++)
		begin
			wr(8'h04, 32'h1 << b);
			settle();
			chk({digital_loop_en, external_loop_en, internal_loop_en}, 3'h1 << (b - 4));
			chk(rx_mux_sel_tx, b == 5);
			chk(tx_in_sel_rx, b == 4);
			repeat (12) @(posedge mclk);
			chk(tx_loop_bit, b == 4);
		end
		wr(8'h04, 32'h0);
		settle();
		chk({rx_mux_sel_tx, tx_in_sel_rx}, 2'h0);
		$display("test loopback routing done");
	endtask

	// Steady ones give a positive, steady zeros a negative sample, short of full scale
	task t_stream(input logic r, input logic t, input logic dig, input logic neg);
		rx_level <= r;
		tx_level <= t;
		wr(8'h04, {25'h0, dig, 6'h0});
		repeat (40) wait_valid();
		e = 0;
		do
		begin
			@(posedge mclk);
			e++;
		end
		while (rx_sample_valid !== 1'b1);
		chk(e, 384);
		chk(rx_sample[15], neg);
		chk(rx_sample == 16'h0, 1'b0);
		rd(8'h0c, v);
		chk(v, {15'h0, 1'b1, rx_sample});
		$display("test sample stream done");
	endtask

	task t_off;
		wr(8'h00, 32'h0);
		settle();
		ticks(400);
		chk(n, 0);
		chk(rx_sample_valid, 1'b0);
		rd(8'h0c, v);
		chk(v[16], 1'b0);
		$display("test front end off done");
	endtask

	task results;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ============================================================
	// Main sequence and watchdog
	initial
	begin
		resetn = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		rx_level = 1'b0;
		tx_level = 1'b0;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		t_reset();
		t_regs();
		t_power();
		t_rate();
		t_loops();
		t_stream(1'b1, 1'b0, 1'b0, 1'b0);
		t_stream(1'b0, 1'b1, 1'b0, 1'b1);
		t_stream(1'b0, 1'b1, 1'b1, 1'b0);
		t_off();
		results();
	end

	initial
	begin
		repeat (90000) @(posedge mclk);
		n_errors++;
		$display("watchdog expired");
		results();
	end
endmodule
